// ### pkg/ctsm_pkg.sv
// Behaviour
// [R1] Power-on reset puts the chip in idle.
// [R2] Idle goes to first level ready on REQA or WUPA; else stays idle.
// [R3] HLTA from active or authenticated makes halt the waiting state.
// [R4] First level ready answers level 1 anticollision and select.
// [R5] Matching level 1 select answers SAK 04h and enters second level ready.
// [R6] READ of page 00h in a ready state answers and enters active.
// [R7] Unexpected frames in a ready state fall back to the waiting state.
// [R8] Second level ready answers level 2 anticollision with the last 4 bytes.
// [R9] Matching level 2 select answers SAK 00h and enters active.
// [R10] Active accepts READ, WRITE, legacy write and authentication start.
// [R11] A passed authentication enters the authenticated state.
// [R12] HLTA in active enters halt.
// [R13] Other commands in active fall back to the waiting state.
// [R14] Halt is left only by WUPA or field reset.
// [R15] Authenticated state may also access protected pages.
// [R16] Frames start with one start bit; each byte carries odd parity.
// [R17] Bytes go out LSB first in ascending address order.
// [R18] No frame exceeds 164 bits.
// [R19] Check CRC, parity, bit count, bit coding and command sequence.
// [R20] Erased cells read 0, written cells read 1.
// [R21] 48 pages of 32 bits with identifier, lock, one-time and user pages.
// [R22] Upper pages hold lock, counter, protection setup and key.
// [R23] Lock byte writes OR into the stored bits.
// [R24] One-time page writes OR into the stored bits.
// [R25] Field loss resets to idle and clears halt history.
package ctsm_pkg;
  localparam logic [6:0] CMD_REQA = 7'h26;
  localparam logic [6:0] CMD_WUPA = 7'h52;
  localparam logic [7:0] CMD_SEL1 = 8'h93;
  localparam logic [7:0] CMD_SEL2 = 8'h95;
  localparam logic [7:0] NVB_ANTI = 8'h20;
  localparam logic [7:0] NVB_SEL = 8'h70;
  localparam logic [7:0] CMD_READ = 8'h30;
  localparam logic [7:0] CMD_WRITE = 8'hA2;
  localparam logic [7:0] CMD_CWRITE = 8'hA0;
  localparam logic [7:0] CMD_AUTH = 8'h1A;
  localparam logic [7:0] CMD_HALT = 8'h50;
  localparam logic [7:0] CASCADE_TAG = 8'h88;
  localparam logic [7:0] SAK_CL1 = 8'h04;
  localparam logic [7:0] SAK_CL2 = 8'h00;
  localparam logic [3:0] ACK = 4'hA;
  localparam logic [3:0] NAK = 4'h0;
  localparam int PG_NUM = 48;
  localparam logic [6:0] PG_COUNT = 7'h30;
  localparam logic [5:0] PG_LOCK0 = 6'h02;
  localparam logic [5:0] PG_OTP = 6'h03;
  localparam logic [5:0] PG_LOCK1 = 6'h28;
  localparam logic [5:0] PG_AUTHCFG = 6'h2A;
  localparam logic [7:0] PROT_OFF = 8'h30;
  localparam int FRAME_BYTES = 18;
  localparam logic [4:0] LEN_SHORT = 5'h02;
  localparam logic [4:0] LEN_CMD = 5'h04;
  localparam logic [4:0] LEN_UID = 5'h05;
  localparam logic [4:0] LEN_WR = 5'h08;
  localparam logic [4:0] LEN_SEL = 5'h09;
  localparam logic [4:0] LEN_RD = 5'h10;
  localparam logic [4:0] LEN_FULL = 5'h12;
  localparam logic [7:0] MAX_FRAME_BITS = 8'hA4;
  localparam logic [7:0] FRAME_MARKS = 8'h02;
  localparam logic [7:0] SHORT_BITS = 8'h07;
  localparam logic [3:0] PAR_POS = 4'h8;
  localparam logic [3:0] NIB_BITS = 4'h4;
  localparam logic [15:0] CRC_INIT = 16'h6363;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  typedef logic [7:0] ctsm_byte_t;
  typedef logic [FRAME_BYTES-1:0][7:0] ctsm_frame_t;
  typedef enum logic [3:0] {
    CTSM_IDLE, CTSM_FIRST_LEVEL_READY_STATE, CTSM_SECOND_LEVEL_READY_STATE,
    CTSM_ACTIVE, CTSM_AUTH_WAIT, CTSM_AUTHENTICATED, CTSM_HALT, CTSM_CWR_DATA
  } ctsm_state_t;
  typedef struct packed {
    logic [4:0] nbytes;
    logic short_f;
    logic [6:0] code;
    logic err;
    logic crc_ok;
  } ctsm_rxinfo_t;
  typedef struct packed {
    logic [4:0] len;
    logic add_crc;
    logic nib_f;
    logic [3:0] nib;
  } ctsm_rsp_t;

  // One byte of the ISO 14443-A CRC, reflected, low bit first.
  function automatic logic [15:0] ctsm_crc_byte(input logic [15:0] crc, input ctsm_byte_t d);
    logic [15:0] r;
    r = crc ^ {8'h00, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ### design/ctsm_core.sv
module ctsm_core
  import ctsm_pkg::*;
#(
  // Identifier bytes, low byte first; the value is arbitrary.
  parameter logic [55:0] P_UID = 56'h66554433221101,
  parameter logic [15:0] P_ATQA = 16'h0044
) (
  // System clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Field presence from the front end, asynchronous.
  input wire logic i_field_on,
  // Demodulated receive bits on the link clock.
  input wire logic i_lnk_clk,
  input wire logic i_rx_sof,
  input wire logic i_rx_vld,
  input wire logic i_rx_bit,
  input wire logic i_rx_cerr,
  input wire logic i_rx_eof,
  // Modulator bits on the link clock.
  output logic o_tx_act,
  output logic o_tx_bit,
  // Crypto control unit on the system clock.
  output logic o_auth_req,
  input wire logic i_auth_done,
  input wire logic i_auth_pass
);

  typedef struct packed {
    logic rx_on;
    logic [7:0] nb;
    logic [3:0] bin;
    ctsm_byte_t sh;
    logic [4:0] idx;
    logic err;
    logic [15:0] crc;
    ctsm_frame_t rbuf;
    ctsm_rxinfo_t info;
    logic rx_tgl;
    logic ack_s1;
    logic ack_s2;
    logic tx_s1;
    logic tx_s2;
    logic tx_seen;
    logic tx_on;
    logic tx_start;
    logic [4:0] tx_idx;
    logic [3:0] tx_bin;
    logic [15:0] tx_crc;
    logic tx_act;
    logic tx_bit;
  } ctsm_lnk_t;

  typedef struct packed {
    ctsm_state_t st;
    logic halted;
    logic cwr_auth;
    logic [5:0] cwr_pg;
    logic rx_s1;
    logic rx_s2;
    logic rx_seen;
    logic tx_tgl;
    logic txd_s1;
    logic txd_s2;
    logic fld_s1;
    logic fld_s2;
    logic auth_req;
    logic [PG_NUM-1:0][31:0] mem;
    ctsm_frame_t rsp;
    ctsm_rsp_t ri;
  } ctsm_cor_t;

  // Reset image: identifier and check bytes, protection setup page at 2Ah holding 30h, all other cells erased.
  function automatic ctsm_cor_t cor_init();
    ctsm_cor_t r;
    ctsm_byte_t bcc0;
    ctsm_byte_t bcc1;
    r = '0;
    bcc0 = CASCADE_TAG ^ P_UID[7:0] ^ P_UID[15:8] ^ P_UID[23:16];
    bcc1 = P_UID[31:24] ^ P_UID[39:32] ^ P_UID[47:40] ^ P_UID[55:48];
    r.st = CTSM_IDLE; // R1
    r.mem[0] = {bcc0, P_UID[23:0]}; // R21
    r.mem[1] = P_UID[55:24];
    r.mem[2] = {24'h000000, bcc1};
    r.mem[PG_AUTHCFG] = {24'h000000, PROT_OFF}; // R22
    return r;
  endfunction

  // Page of a read burst, wrapping past the last page.
  function automatic logic [5:0] pg_wrap(input logic [5:0] base, input logic [1:0] i);
    logic [6:0] s;
    s = {1'h0, base} + {5'h00, i};
    if (s >= PG_COUNT) begin
      s = s - PG_COUNT;
    end
    return s[5:0];
  endfunction

  // New page content after a write; lock and one-time bits only set.
  function automatic logic [31:0] wr_merge(input logic [5:0] pg, input logic [31:0] o,
                                           input logic [31:0] d);
    logic [31:0] r;
    r = d;
    if (pg == PG_LOCK0) begin
      r = {o[31:16] | d[31:16], o[15:0]}; // R23
    end else if (pg == PG_OTP) begin
      r = o | d; // R24
    end else if (pg == PG_LOCK1) begin
      r = {o[31:16], o[15:0] | d[15:0]}; // R23
    end
    return r;
  endfunction

  // Well-formed frame check for a given opcode and length.
  function automatic logic cmd_is(input ctsm_rxinfo_t f, input ctsm_byte_t op,
                                  input ctsm_byte_t want, input logic [4:0] len, input logic crc);
    return !f.err && !f.short_f && (op == want) && (f.nbytes == len) && (f.crc_ok || !crc);
  endfunction

  localparam ctsm_cor_t C_RST = cor_init();

  ctsm_lnk_t l;
  ctsm_lnk_t nl;
  ctsm_cor_t c;
  ctsm_cor_t nc;
  logic lrst_s1;
  logic lrst_s2;
  logic busy;
  logic [4:0] tx_len;
  ctsm_byte_t tb;
  ctsm_state_t wait_st;
  ctsm_rxinfo_t inf;
  ctsm_frame_t rb;
  logic [5:0] pg;
  logic pg_ok;
  logic prot;
  logic wr_ok;
  logic send;
  logic authed;
  logic [39:0] cl1;
  logic [39:0] cl2;
  logic [31:0] wd;

  // Reset brought into the link domain.
  always_ff @(posedge i_lnk_clk) begin
    lrst_s1 <= i_rst_n;
    lrst_s2 <= lrst_s1;
  end

  // Link side: frame receiver with checks, and serialiser.
  always_comb begin
    nl = l;
    busy = l.rx_tgl != l.ack_s2;
    tb = 8'h00;
    tx_len = c.ri.len + (c.ri.add_crc ? LEN_SHORT : 5'h00);
    nl.ack_s1 = c.rx_seen;
    nl.ack_s2 = l.ack_s1;
    nl.tx_s1 = c.tx_tgl;
    nl.tx_s2 = l.tx_s1;
    if (i_rx_sof && !busy) begin
      nl.rx_on = 1'h1;
      nl.nb = 8'h00;
      nl.bin = 4'h0;
      nl.idx = 5'h00;
      nl.err = 1'h0;
      nl.crc = CRC_INIT;
    end else if (l.rx_on && i_rx_vld) begin
      nl.nb = l.nb + 8'h01;
      if (l.nb >= MAX_FRAME_BITS - FRAME_MARKS) begin
        nl.err = 1'h1; // R18
      end
      if (l.bin == PAR_POS) begin
        nl.bin = 4'h0;
        if (!(^{l.sh, i_rx_bit})) begin
          nl.err = 1'h1; // R16
        end
        if (l.idx < LEN_FULL) begin
          nl.rbuf[l.idx] = l.sh; // R17
          nl.idx = l.idx + 5'h01;
        end
        nl.crc = ctsm_crc_byte(l.crc, l.sh); // R19
      end else begin
        nl.sh = {i_rx_bit, l.sh[7:1]}; // R17
        nl.bin = l.bin + 4'h1;
      end
    end
    if (l.rx_on && i_rx_cerr) begin
      nl.err = 1'h1; // R19
    end
    if (l.rx_on && i_rx_eof) begin
      nl.rx_on = 1'h0;
      nl.info.short_f = (l.nb == SHORT_BITS) && (l.idx == 5'h00);
      nl.info.code = l.sh[7:1];
      nl.info.nbytes = l.idx;
      nl.info.err = l.err || i_rx_cerr || ((l.bin != 4'h0) && !nl.info.short_f); // R19
      nl.info.crc_ok = l.crc == CRC_RESIDUE; // R19
      nl.rx_tgl = ~l.rx_tgl;
    end
    // Transmit one bit per link clock.
    if (!l.tx_on && (l.tx_s2 != l.tx_seen)) begin
      nl.tx_on = 1'h1;
      nl.tx_start = 1'h1;
      nl.tx_idx = 5'h00;
      nl.tx_bin = 4'h0;
      nl.tx_crc = CRC_INIT;
    end else if (l.tx_on) begin
      if (l.tx_idx < c.ri.len) begin
        tb = c.rsp[l.tx_idx];
      end else if (l.tx_idx == c.ri.len) begin
        tb = l.tx_crc[7:0];
      end else begin
        tb = l.tx_crc[15:8];
      end
      if (l.tx_start) begin
        nl.tx_start = 1'h0;
        nl.tx_act = 1'h1;
        nl.tx_bit = 1'h1; // R16
      end else if (c.ri.nib_f ? (l.tx_bin == NIB_BITS) : (l.tx_idx == tx_len)) begin
        nl.tx_on = 1'h0;
        nl.tx_act = 1'h0;
        nl.tx_bit = 1'h0;
        nl.tx_seen = l.tx_s2;
      end else if (c.ri.nib_f) begin
        nl.tx_bit = c.ri.nib[l.tx_bin[1:0]];
        nl.tx_bin = l.tx_bin + 4'h1;
      end else if (l.tx_bin != PAR_POS) begin
        nl.tx_bit = tb[l.tx_bin[2:0]]; // R17
        nl.tx_bin = l.tx_bin + 4'h1;
      end else begin
        nl.tx_bit = ~^tb; // R16
        nl.tx_bin = 4'h0;
        nl.tx_idx = l.tx_idx + 5'h01;
        if (l.tx_idx < c.ri.len) begin
          nl.tx_crc = ctsm_crc_byte(l.tx_crc, tb); // R19
        end
      end
    end
  end

  // Link domain register.
  always_ff @(posedge i_lnk_clk) begin
    if (!lrst_s2) begin
      l <= '0;
    end else begin
      l <= nl;
    end
  end

  // Command interpreter and page memory.
  always_comb begin
    nc = c;
    send = 1'h0;
    nc.rx_s1 = l.rx_tgl;
    nc.rx_s2 = c.rx_s1;
    nc.txd_s1 = l.tx_seen;
    nc.txd_s2 = c.txd_s1;
    nc.fld_s1 = i_field_on;
    nc.fld_s2 = c.fld_s1;
    nc.auth_req = 1'h0;
    wait_st = c.halted ? CTSM_HALT : CTSM_IDLE;
    inf = l.info;
    rb = l.rbuf;
    pg = rb[1][5:0];
    pg_ok = rb[1] < {1'h0, PG_COUNT};
    authed = c.st == CTSM_AUTHENTICATED;
    prot = !authed && (rb[1] >= c.mem[PG_AUTHCFG][7:0]); // R15
    wr_ok = pg_ok && !prot && (pg >= PG_LOCK0);
    wd = rb[5:2];
    cl1 = {c.mem[0], CASCADE_TAG};
    cl2 = {c.mem[2][7:0], c.mem[1]};
    if ((c.rx_s2 != c.rx_seen) && (c.txd_s2 == c.tx_tgl)) begin
      nc.rx_seen = c.rx_s2;
      nc.ri = '0;
      case (c.st)
        CTSM_IDLE, CTSM_HALT: begin
          if (!inf.err && inf.short_f &&
              (inf.code == CMD_WUPA || (inf.code == CMD_REQA && c.st == CTSM_IDLE))) begin
            nc.st = CTSM_FIRST_LEVEL_READY_STATE; // R2 R14
            nc.rsp[1:0] = P_ATQA;
            nc.ri.len = LEN_SHORT;
            send = 1'h1;
          end
        end
        CTSM_FIRST_LEVEL_READY_STATE, CTSM_SECOND_LEVEL_READY_STATE: begin
          nc.st = wait_st; // R7
          if (cmd_is(inf, rb[0], CMD_READ, LEN_CMD, 1'h1) && rb[1] == 8'h00) begin
            nc.st = CTSM_ACTIVE; // R6
            for (int i = 0; i < 4; i++) begin
              nc.rsp[i*4 +: 4] = c.mem[pg_wrap(6'h00, 2'(i))];
            end
            nc.ri.len = LEN_RD;
            nc.ri.add_crc = 1'h1;
            send = 1'h1;
          end else if (c.st == CTSM_FIRST_LEVEL_READY_STATE) begin
            if (cmd_is(inf, rb[0], CMD_SEL1, LEN_SHORT, 1'h0) && rb[1] == NVB_ANTI) begin
              nc.st = c.st; // R4
              nc.rsp[4:0] = cl1;
              nc.ri.len = LEN_UID;
              send = 1'h1;
            end else if (cmd_is(inf, rb[0], CMD_SEL1, LEN_SEL, 1'h1) &&
                         rb[1] == NVB_SEL && rb[6:2] == cl1) begin
              nc.st = CTSM_SECOND_LEVEL_READY_STATE; // R5
              nc.rsp[0] = SAK_CL1;
              nc.ri.len = 5'h01;
              nc.ri.add_crc = 1'h1;
              send = 1'h1;
            end
          end else begin
            if (cmd_is(inf, rb[0], CMD_SEL2, LEN_SHORT, 1'h0) && rb[1] == NVB_ANTI) begin
              nc.st = c.st; // R8
              nc.rsp[4:0] = cl2;
              nc.ri.len = LEN_UID;
              send = 1'h1;
            end else if (cmd_is(inf, rb[0], CMD_SEL2, LEN_SEL, 1'h1) &&
                         rb[1] == NVB_SEL && rb[6:2] == cl2) begin
              nc.st = CTSM_ACTIVE; // R9
              nc.rsp[0] = SAK_CL2;
              nc.ri.len = 5'h01;
              nc.ri.add_crc = 1'h1;
              send = 1'h1;
            end
          end
        end
        CTSM_ACTIVE, CTSM_AUTHENTICATED: begin
          nc.st = wait_st; // R13
          nc.ri.nib_f = 1'h1;
          nc.ri.nib = NAK;
          send = !inf.err && inf.crc_ok;
          if (cmd_is(inf, rb[0], CMD_READ, LEN_CMD, 1'h1) && pg_ok && !prot) begin
            nc.st = c.st; // R10 R15
            for (int i = 0; i < 4; i++) begin
              nc.rsp[i*4 +: 4] = c.mem[pg_wrap(pg, 2'(i))]; // R20
            end
            nc.ri = '0;
            nc.ri.len = LEN_RD;
            nc.ri.add_crc = 1'h1;
          end else if (cmd_is(inf, rb[0], CMD_WRITE, LEN_WR, 1'h1) && wr_ok) begin
            nc.st = c.st; // R10
            nc.mem[pg] = wr_merge(pg, c.mem[pg], wd);
            nc.ri.nib = ACK;
          end else if (cmd_is(inf, rb[0], CMD_CWRITE, LEN_CMD, 1'h1) && wr_ok) begin
            nc.st = CTSM_CWR_DATA; // R10
            nc.cwr_pg = pg;
            nc.cwr_auth = authed;
            nc.ri.nib = ACK;
          end else if (cmd_is(inf, rb[0], CMD_AUTH, LEN_CMD, 1'h1)) begin
            nc.st = CTSM_AUTH_WAIT; // R10
            nc.auth_req = 1'h1;
            send = 1'h0;
          end else if (cmd_is(inf, rb[0], CMD_HALT, LEN_CMD, 1'h1) && rb[1] == 8'h00) begin
            nc.st = CTSM_HALT; // R3 R12
            nc.halted = 1'h1;
            send = 1'h0;
          end
        end
        CTSM_CWR_DATA: begin
          nc.st = wait_st; // R19
          if (!inf.err && !inf.short_f && inf.crc_ok && inf.nbytes == LEN_FULL) begin
            nc.st = c.cwr_auth ? CTSM_AUTHENTICATED : CTSM_ACTIVE;
            nc.mem[c.cwr_pg] = wr_merge(c.cwr_pg, c.mem[c.cwr_pg], rb[3:0]);
            nc.ri.nib_f = 1'h1;
            nc.ri.nib = ACK;
            send = 1'h1;
          end
        end
        default: begin
          nc.st = c.st;
        end
      endcase
    end
    // The crypto result wins over a frame swallowed in the same cycle.
    if (c.st == CTSM_AUTH_WAIT && i_auth_done) begin
      nc.st = i_auth_pass ? CTSM_AUTHENTICATED : wait_st; // R11
    end
    if (send) begin
      nc.tx_tgl = ~c.tx_tgl;
    end
    if (!c.fld_s2) begin
      nc.st = CTSM_IDLE; // R25
      nc.halted = 1'h0;
    end
  end

  // System domain register.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      c <= C_RST; // R1
    end else begin
      c <= nc;
    end
  end

  assign o_tx_act = l.tx_act;
  assign o_tx_bit = l.tx_bit;
  assign o_auth_req = c.auth_req;

endmodule

// ### bench/ctsm_core_asserts.sv
module ctsm_core_asserts
  import ctsm_pkg::*;
(
  // System clock domain.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_field_on,
  input wire logic i_auth_done,
  input wire logic i_auth_pass,
  input wire logic o_auth_req,
  // Link clock domain.
  input wire logic i_lnk_clk,
  input wire logic i_rx_sof,
  input wire logic i_rx_vld,
  input wire logic i_rx_bit,
  input wire logic i_rx_cerr,
  input wire logic i_rx_eof,
  input wire logic o_tx_act,
  input wire logic o_tx_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] len_ff;
  logic [3:0] pos_ff;
  logic par_ff;

  // Counts the bits of an outgoing frame and folds each data bit into a parity sum.
  always_ff @(posedge i_lnk_clk) begin
    if (!i_rst_n || !o_tx_act) begin
      len_ff <= 8'h00;
      pos_ff <= 4'h0;
      par_ff <= 1'b0;
    end else begin
      len_ff <= len_ff + 8'h01;
      pos_ff <= (len_ff == 8'h00 || pos_ff == 4'h8) ? 4'h0 : pos_ff + 4'h1;
      par_ff <= (len_ff == 8'h00 || pos_ff == 4'h8) ? 1'b0 : par_ff ^ o_tx_bit;
    end
  end

  a_start_bit: assert property (
    @(posedge i_lnk_clk) disable iff (!i_rst_n) $rose(o_tx_act) |-> o_tx_bit)
    else $error("answer frame does not open with a one");
  a_odd_parity: assert property (
    @(posedge i_lnk_clk) disable iff (!i_rst_n)
    (o_tx_act && len_ff != 8'h00 && pos_ff == 4'h8) |-> (o_tx_bit == ~par_ff))
    else $error("parity bit is not odd");
  a_frame_max: assert property (
    @(posedge i_lnk_clk) disable iff (!i_rst_n) o_tx_act |-> (len_ff < MAX_FRAME_BITS - 8'h01))
    else $error("answer frame too long");
  a_frame_shape: assert property (
    @(posedge i_lnk_clk) disable iff (!i_rst_n)
    $fell(o_tx_act) |-> (len_ff == 8'h05 || (len_ff - 8'h01) % 9 == 0))
    else $error("answer frame is not whole bytes or one nibble");
  a_rsp_gap: assert property (
    @(posedge i_lnk_clk) disable iff (!i_rst_n) i_rx_eof |=> !o_tx_act [*2])
    else $error("answer starts too soon after frame end");
  a_half_duplex: assert property (
    @(posedge i_lnk_clk) disable iff (!i_rst_n) i_rx_vld |-> !o_tx_act)
    else $error("answer overlaps incoming bits");
  a_auth_pulse: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n) o_auth_req |=> !o_auth_req)
    else $error("auth request longer than one cycle");
  a_auth_quiet: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n) o_auth_req |-> !o_tx_act)
    else $error("auth request while answering");
  a_field_idle: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n) !i_field_on [*5] |-> !o_auth_req)
    else $error("auth request without field");
endmodule

// ### bench/ctsm_reader.sv
module ctsm_reader
  import ctsm_pkg::*;
(
  // Link bit clock and modulator bits from the chip.
  input wire logic i_lnk_clk,
  input wire logic i_tx_act,
  input wire logic i_tx_bit,
  // Demodulated bits towards the chip.
  output logic o_sof,
  output logic o_vld,
  output logic o_bit,
  output logic o_cerr,
  output logic o_eof
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rxq[$];

  // Lines start quiet.
  initial begin
    o_sof = 1'b0;
    o_vld = 1'b0;
    o_bit = 1'b0;
    o_cerr = 1'b0;
    o_eof = 1'b0;
  end

  // Collects every bit the chip modulates.
  always @(posedge i_lnk_clk) begin
    if (i_tx_act) rxq.push_back(i_tx_bit);
  end

  // Frame check over a byte list, low bit first.
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  task automatic put(input logic v);
    @(posedge i_lnk_clk) #1;
    o_vld = 1'b1;
    o_bit = v;
  endtask

  // Sends one frame: md 0 plain, 1 bad parity, 2 coding error, 3 short frame.
  task automatic send(input logic [7:0] b[$], input bit ac, input int md);
    logic [15:0] c;
    c = crc(b);
    if (ac) begin
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
    end
    rxq.delete();
    @(posedge i_lnk_clk) #1;
    o_sof = 1'b1;
    @(posedge i_lnk_clk) #1;
    o_sof = 1'b0;
    if (md == 3) begin
      for (int k = 0; k < 7; k++) put(b[0][k]);
    end else begin
      foreach (b[i]) begin
        for (int k = 0; k < 8; k++) put(b[i][k]);
        put(~^b[i] ^ (md == 1));
      end
    end
    @(posedge i_lnk_clk) #1;
    o_vld = 1'b0;
    o_bit = ~o_bit;
    o_cerr = (md == 2);
    @(posedge i_lnk_clk) #1;
    o_cerr = 1'b0;
    o_eof = 1'b1;
    @(posedge i_lnk_clk) #1;
    o_eof = 1'b0;
  endtask

  // Waits for the answer to end or a silent span, then keeps the turnaround gap.
  task automatic wait_rsp();
    for (int i = 0; i < 220; i++) begin
      @(posedge i_lnk_clk);
      if (rxq.size() > 0 && !i_tx_act) break;
    end
    repeat (12) @(posedge i_lnk_clk);
  endtask
endmodule

// ### bench/test_contactless_ticket_state_machine.sv
module test_contactless_ticket_state_machine
  import ctsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Identifier for the bench; the value is arbitrary.
  localparam logic [55:0] UID = 56'h7A6B5C4D3E2F10;
  localparam logic [15:0] ATQA = 16'h0044;
  localparam logic [7:0] BCC0 = CASCADE_TAG ^ UID[7:0] ^ UID[15:8] ^ UID[23:16];
  localparam logic [7:0] BCC1 = UID[31:24] ^ UID[39:32] ^ UID[47:40] ^ UID[55:48];
  localparam logic [7:0] REQ = {1'b0, CMD_REQA};
  localparam logic [7:0] WUP = {1'b0, CMD_WUPA};
  logic i_mclk = 1'b0;
  logic i_lnk_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_field_on = 1'b1;
  logic i_auth_done = 1'b0;
  logic i_auth_pass = 1'b0;
  logic sof, vld, rbit, cerr, eof, tx_act, tx_bit, auth_req;
  logic [7:0] q[$];
  int num_errors = 0;
  int n_checks = 0;
  int n_auth = 0;

  // System clock, and a link clock started off phase.
  always #10 i_mclk = ~i_mclk;
  initial begin
    #7;
    forever #32 i_lnk_clk = ~i_lnk_clk;
  end

  ctsm_core #(.P_UID(UID), .P_ATQA(ATQA)) dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_field_on(i_field_on), .i_lnk_clk(i_lnk_clk),
    .i_rx_sof(sof), .i_rx_vld(vld), .i_rx_bit(rbit), .i_rx_cerr(cerr), .i_rx_eof(eof),
    .o_tx_act(tx_act), .o_tx_bit(tx_bit), .o_auth_req(auth_req),
    .i_auth_done(i_auth_done), .i_auth_pass(i_auth_pass));
  ctsm_reader rd (.i_lnk_clk(i_lnk_clk), .i_tx_act(tx_act), .i_tx_bit(tx_bit), .o_sof(sof),
    .o_vld(vld), .o_bit(rbit), .o_cerr(cerr), .o_eof(eof));

  // Counts auth requests towards the crypto unit.
  always @(posedge i_mclk) begin
    if (auth_req === 1'b1) n_auth++;
  end

  function automatic logic [7:0] u(input int i);
    return UID[8*i+:8];
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic x(input logic [7:0] b[$], input bit ac = 1, input int md = 0);
    rd.send(b, ac, md);
    rd.wait_rsp();
  endtask

  // Compares the answer bit by bit with the bytes given, plus frame check if asked.
  task automatic ex(input logic [7:0] e[$], input bit ac);
    logic [15:0] c;
    logic [7:0] v;
    c = rd.crc(e);
    if (ac) begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    chk("len", rd.rxq.size(), 1 + 9 * e.size());
    chk("start", {31'h0, rd.rxq[0]}, 32'h1);
    foreach (e[i]) begin
      for (int k = 0; k < 8; k++) v[k] = rd.rxq[1 + 9 * i + k];
      chk("byte", {24'h0, v}, {24'h0, e[i]});
      chk("par", {31'h0, rd.rxq[9 + 9 * i]}, {31'h0, ~^e[i]});
    end
  endtask

  task automatic nib(input logic [3:0] n);
    chk("len", rd.rxq.size(), 5);
    chk("nib", {28'h0, rd.rxq[4], rd.rxq[3], rd.rxq[2], rd.rxq[1]}, {28'h0, n});
  endtask

  task automatic quiet();
    chk("quiet", rd.rxq.size(), 0);
  endtask

  task automatic req(input logic [7:0] code);
    x('{code}, 0, 3);
    ex('{ATQA[7:0], ATQA[15:8]}, 0);
  endtask

  task automatic act();
    req(REQ);
    x('{CMD_READ, 8'h00});
    chk("len", rd.rxq.size(), 163);
  endtask

  task automatic t_errors();
    x('{CMD_READ, 8'h00});
    quiet();
    req(REQ);
    x('{CMD_SEL1, NVB_ANTI}, 0, 1);
    quiet();
    x('{CMD_SEL1, NVB_ANTI}, 0);
    quiet();
    req(REQ);
    x('{CMD_SEL1, NVB_ANTI}, 0, 2);
    quiet();
    x('{CMD_SEL1, NVB_ANTI}, 0);
    quiet();
  endtask

  task automatic t_select();
    req(REQ);
    x('{CMD_SEL1, NVB_ANTI}, 0);
    ex('{CASCADE_TAG, u(0), u(1), u(2), BCC0}, 0);
    x('{CMD_SEL1, NVB_SEL, CASCADE_TAG, u(0), u(1), u(2), BCC0});
    ex('{SAK_CL1}, 1);
    x('{CMD_SEL2, NVB_ANTI}, 0);
    ex('{u(3), u(4), u(5), u(6), BCC1}, 0);
    x('{CMD_SEL2, NVB_SEL, u(3), u(4), u(5), u(6), BCC1});
    ex('{SAK_CL2}, 1);
    x('{CMD_READ, 8'h00});
    q = '{u(0), u(1), u(2), BCC0, u(3), u(4), u(5), u(6), BCC1};
    repeat (7) q.push_back(8'h00);
    ex(q, 1);
    x('{8'h60, 8'h00});
    nib(NAK);
  endtask

  task automatic t_write();
    act();
    x('{CMD_WRITE, 8'h04, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
    nib(ACK);
    x('{CMD_WRITE, 8'h03, 8'h0F, 8'h0F, 8'h0F, 8'h0F});
    nib(ACK);
    x('{CMD_WRITE, 8'h03, 8'hF0, 8'hF0, 8'hF0, 8'hF0});
    nib(ACK);
    x('{CMD_WRITE, 8'h02, 8'h11, 8'h22, 8'h01, 8'h02});
    nib(ACK);
    x('{CMD_WRITE, 8'h02, 8'h11, 8'h22, 8'h04, 8'h08});
    nib(ACK);
    x('{CMD_CWRITE, 8'h05});
    nib(ACK);
    q = {};
    for (int i = 0; i < 16; i++) q.push_back(8'h40 + 8'(i));
    x(q);
    nib(ACK);
    x('{CMD_READ, 8'h02});
    q = '{BCC1, 8'h00, 8'h05, 8'h0A, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hA1, 8'hB2, 8'hC3, 8'hD4};
    q = {q, 8'h40, 8'h41, 8'h42, 8'h43};
    ex(q, 1);
    x('{CMD_HALT, 8'h00});
    quiet();
  endtask

  task automatic t_halt();
    x('{REQ}, 0, 3);
    quiet();
    x('{CMD_READ, 8'h00});
    quiet();
    req(WUP);
    x('{8'h60, 8'h00});
    quiet();
    x('{REQ}, 0, 3);
    quiet();
    @(posedge i_mclk) #1;
    i_field_on = 1'b0;
    repeat (20) @(posedge i_mclk);
    #1;
    i_field_on = 1'b1;
    repeat (20) @(posedge i_mclk);
    req(REQ);
    x('{8'h60, 8'h00});
    quiet();
  endtask

  task automatic t_auth();
    act();
    x('{CMD_WRITE, 8'h2A, 8'h04, 8'h00, 8'h00, 8'h00});
    nib(ACK);
    x('{CMD_READ, 8'h04});
    nib(NAK);
    act();
    x('{CMD_AUTH, 8'h00});
    quiet();
    chk("auth", n_auth, 1);
    @(posedge i_mclk) #1;
    i_auth_done = 1'b1;
    i_auth_pass = 1'b1;
    @(posedge i_mclk) #1;
    i_auth_done = 1'b0;
    i_auth_pass = 1'b0;
    x('{CMD_READ, 8'h04});
    q = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h40, 8'h41, 8'h42, 8'h43};
    repeat (8) q.push_back(8'h00);
    ex(q, 1);
    x('{CMD_AUTH, 8'h00});
    quiet();
    chk("auth", n_auth, 2);
    @(posedge i_mclk) #1;
    i_auth_done = 1'b1;
    @(posedge i_mclk) #1;
    i_auth_done = 1'b0;
    x('{CMD_READ, 8'h04});
    quiet();
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence after reset.
  initial begin
    repeat (4) @(posedge i_lnk_clk);
    @(posedge i_mclk) #1;
    i_rst_n = 1'b1;
    repeat (8) @(posedge i_lnk_clk);
    t_errors();
    t_select();
    t_write();
    t_halt();
    t_auth();
    conclude();
  end

  // Cuts a hang short.
  initial begin
    #1800000;
    num_errors++;
    conclude();
  end
endmodule

bind ctsm_core ctsm_core_asserts chk_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_field_on(i_field_on), .i_auth_done(i_auth_done), .i_auth_pass(i_auth_pass),
  .o_auth_req(o_auth_req), .i_lnk_clk(i_lnk_clk), .i_rx_sof(i_rx_sof), .i_rx_vld(i_rx_vld),
  .i_rx_bit(i_rx_bit), .i_rx_cerr(i_rx_cerr), .i_rx_eof(i_rx_eof), .o_tx_act(o_tx_act),
  .o_tx_bit(o_tx_bit));
